// File: core/msc_pkg.sv
// Constants and helpers shared by the MAC statistics counter block
// Behaviour
// - count good received frames of 512 to 1023 bytes, 20 bits
// - count good received frames of 1024 to 1518 bytes, 20 bits
// - count good received frames longer than 1518 bytes, 20 bits
// - receive size bins ignore filter-rejected and FIFO-overflow frames
// - 32-bit count of low-power-idle indication rising edges from the PHY
// - 32-bit count of microseconds spent with receive low-power idle indicated
// - both low-power-idle counters stay zero while efficient-Ethernet enable is low
// - low-power-idle counters run in normal, suspend zero and suspend three states
// - 20-bit count of frames transmitted with a bad FCS
// - force-bad-FCS makes the MAC corrupt FCS; such frames count as FCS errors
// - excess deferral is deferral beyond two max-size frame times plus 16 bytes
// - deferral timer restarts from zero at every new deferral
// - 20-bit count of frames with carrier absent or lost during transmission
// - 32-bit total of bytes sent in errored transmissions
// - separate 20-bit counts of good frames after one and after several collisions
// - abort a frame at 16 collisions and count it as excessive collision
// - count frames aborted by late collision
// - byte totals per cast type, good frames only, no pause or partial frames
// - frame counts per cast type, good frames only, no pause frames
// - count every pause frame transmitted successfully
// - transmit size bins up to 511 bytes skip partials; 64 bin skips pause
package msc_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int LEN_W = 14;
    localparam int CNT20_W = 20;
    localparam int CNT32_W = 32;
    localparam int DEFER_W = 16;
    localparam int COL_W = 5;

    // ****************************************************************
    // Frame size bins, in bytes
    // ****************************************************************
    localparam logic [LEN_W-1:0] BIN_512 = 14'h0200;
    localparam logic [LEN_W-1:0] BIN_1023 = 14'h03FF;
    localparam logic [LEN_W-1:0] BIN_1024 = 14'h0400;
    localparam logic [LEN_W-1:0] BIN_1518 = 14'h05EE;
    localparam logic [LEN_W-1:0] BIN_1519 = 14'h05EF;
    localparam logic [LEN_W-1:0] BIN_64 = 14'h0040;
    localparam logic [LEN_W-1:0] BIN_65 = 14'h0041;
    localparam logic [LEN_W-1:0] BIN_127 = 14'h007F;
    localparam logic [LEN_W-1:0] BIN_128 = 14'h0080;
    localparam logic [LEN_W-1:0] BIN_255 = 14'h00FF;
    localparam logic [LEN_W-1:0] BIN_256 = 14'h0100;
    localparam logic [LEN_W-1:0] BIN_511 = 14'h01FF;
    localparam logic [LEN_W-1:0] LEN_MAX = 14'h3FFF;

    // ****************************************************************
    // Transmit limits
    // ****************************************************************
    localparam logic [COL_W-1:0] MAX_COLLISIONS = 5'h10;
    localparam logic [DEFER_W-1:0] DEFER_MARGIN_BYTES = 16'h0010;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int LPI_UNIT_NS = 1000;
    localparam int US_CYCLES = (LPI_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int US_DIV_W = 6;
    localparam logic [US_DIV_W-1:0] US_LAST = US_DIV_W'(US_CYCLES - 1);

    // ****************************************************************
    // Counter bank lanes
    // ****************************************************************
    localparam int FC_N = 18;
    localparam int FC_RX512 = 0;
    localparam int FC_RX1024 = 1;
    localparam int FC_RXBIG = 2;
    localparam int FC_FCS = 3;
    localparam int FC_DEFER = 4;
    localparam int FC_CARRIER = 5;
    localparam int FC_SCOL = 6;
    localparam int FC_MCOL = 7;
    localparam int FC_XCOL = 8;
    localparam int FC_LCOL = 9;
    localparam int FC_UNI = 10;
    localparam int FC_BC = 11;
    localparam int FC_MC = 12;
    localparam int FC_PAUSE = 13;
    localparam int FC_T64 = 14;
    localparam int FC_T65 = 15;
    localparam int FC_T128 = 16;
    localparam int FC_T256 = 17;
    localparam int BC_N = 4;
    localparam int BC_BAD = 0;
    localparam int BC_UNI = 1;
    localparam int BC_BC = 2;
    localparam int BC_MC = 3;

    // Inclusive length range test
    function automatic logic len_in(input logic [LEN_W-1:0] len,
                                    input logic [LEN_W-1:0] lo,
                                    input logic [LEN_W-1:0] hi);
        len_in = (len >= lo) && (len <= hi);
    endfunction

endpackage

// File: core/msc_counter_bank.sv
// Bank of wrapping counters, each advanced by a shared amount
`timescale 1ns/1ps
module msc_counter_bank
    import msc_pkg::*;
#(
    parameter int N = 4,
    parameter int W = 20,
    parameter int AW = 1
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Increment controls
    input wire logic [N-1:0] inc_i,
    input wire logic [AW-1:0] amount_i,
    // Counter values
    output logic [N-1:0][W-1:0] count_o
);

    // ****************************************************************
    // Counters
    // ****************************************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            count_o <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (inc_i[i]) begin
                    count_o[i] <= count_o[i] + W'(amount_i);
                end
            end
        end
    end

endmodule

// File: core/msc_stats.sv
// Receive size bin, receive low-power-idle and transmit statistics counters
`timescale 1ns/1ps
module msc_stats
    import msc_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Receive frame status
    input wire logic rx_done_i,
    input wire logic [LEN_W-1:0] rx_len_i,
    input wire logic rx_err_i,
    input wire logic rx_filter_reject_i,
    input wire logic rx_fifo_overflow_i,
    // Low-power idle and power state
    input wire logic phy_lpi_i,
    input wire logic energy_efficient_enable_i,
    input wire logic pwr_normal_i,
    input wire logic suspend_level_zero_i,
    input wire logic suspend_level_three_i,
    // Transmit control
    input wire logic force_bad_fcs_i,
    input wire logic [LEN_W-1:0] max_frame_size_i,
    input wire logic tx_byte_tick_i,
    input wire logic tx_defer_i,
    input wire logic tx_collision_i,
    // Transmit frame status
    input wire logic tx_done_i,
    input wire logic [LEN_W-1:0] tx_len_i,
    input wire logic tx_fcs_err_i,
    input wire logic tx_carrier_err_i,
    input wire logic tx_late_col_i,
    input wire logic tx_unicast_i,
    input wire logic tx_broadcast_i,
    input wire logic tx_multicast_i,
    input wire logic tx_pause_i,
    input wire logic tx_partial_i,
    // Transmit path controls
    output logic tx_corrupt_fcs_o,
    output logic tx_abort_o,
    // Receive counters
    output logic [CNT20_W-1:0] rx_frames_512_o,
    output logic [CNT20_W-1:0] rx_frames_1024_o,
    output logic [CNT20_W-1:0] rx_frames_big_o,
    output logic [CNT32_W-1:0] rx_lpi_transitions_o,
    output logic [CNT32_W-1:0] rx_lpi_time_o,
    // Transmit error counters
    output logic [CNT20_W-1:0] tx_fcs_errors_o,
    output logic [CNT20_W-1:0] tx_excess_defer_o,
    output logic [CNT20_W-1:0] tx_carrier_errors_o,
    output logic [CNT32_W-1:0] tx_bad_bytes_o,
    output logic [CNT20_W-1:0] tx_single_col_o,
    output logic [CNT20_W-1:0] tx_multi_col_o,
    output logic [CNT20_W-1:0] tx_excess_col_o,
    output logic [CNT20_W-1:0] tx_late_col_o,
    // Transmit traffic counters
    output logic [CNT32_W-1:0] tx_unicast_bytes_o,
    output logic [CNT32_W-1:0] tx_broadcast_bytes_o,
    output logic [CNT32_W-1:0] tx_multicast_bytes_o,
    output logic [CNT20_W-1:0] tx_unicast_frames_o,
    output logic [CNT20_W-1:0] tx_broadcast_frames_o,
    output logic [CNT20_W-1:0] tx_multicast_frames_o,
    output logic [CNT20_W-1:0] tx_pause_frames_o,
    output logic [CNT20_W-1:0] tx_frames_64_o,
    output logic [CNT20_W-1:0] tx_frames_65_o,
    output logic [CNT20_W-1:0] tx_frames_128_o,
    output logic [CNT20_W-1:0] tx_frames_256_o
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic lpi_s1_q;
    logic lpi_s2_q;
    logic lpi_s3_q;
    logic lpi_q;
    logic lpi_prev_q;
    logic lpi_run;
    logic lpi_rise;
    logic [US_DIV_W-1:0] us_div_q;
    logic us_tick_q;
    logic [CNT32_W-1:0] lpi_trans_q;
    logic [CNT32_W-1:0] lpi_time_q;
    logic [DEFER_W-1:0] defer_q;
    logic [DEFER_W-1:0] defer_limit;
    logic defer_over;
    logic defer_excess_q;
    logic frame_defer_excess;
    logic [COL_W-1:0] col_q;
    logic col_excess;
    logic rx_good;
    logic tx_err;
    logic tx_ok;
    logic tx_full;
    logic [FC_N-1:0] fc_inc;
    logic [BC_N-1:0] bc_inc;
    logic [FC_N-1:0][CNT20_W-1:0] fc_cnt;
    logic [BC_N-1:0][CNT32_W-1:0] bc_cnt;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    // ****************************************************************
    // Low-power-idle pin synchroniser
    // ****************************************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            lpi_s1_q <= 1'b0;
            lpi_s2_q <= 1'b0;
            lpi_s3_q <= 1'b0;
        end else begin
            lpi_s1_q <= phy_lpi_i;
            lpi_s2_q <= lpi_s1_q;
            lpi_s3_q <= lpi_s2_q;
        end
    end

    // Level only moves once two stages agree
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            lpi_q <= 1'b0;
            lpi_prev_q <= 1'b0;
        end else begin
            if (lpi_s2_q == lpi_s3_q) begin
                lpi_q <= lpi_s3_q;
            end
            lpi_prev_q <= lpi_q;
        end
    end

    assign lpi_run = pwr_normal_i | suspend_level_zero_i | suspend_level_three_i;
    assign lpi_rise = lpi_q & ~lpi_prev_q;

    // ****************************************************************
    // Microsecond divider
    // ****************************************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            us_div_q <= '0;
            us_tick_q <= 1'b0;
        end else begin
            us_tick_q <= (us_div_q == US_LAST);
            if (us_div_q == US_LAST) begin
                us_div_q <= '0;
            end else begin
                us_div_q <= us_div_q + 1'b1;
            end
        end
    end

    // ****************************************************************
    // Low-power-idle counters
    // ****************************************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            lpi_trans_q <= '0;
        end else if (!energy_efficient_enable_i) begin
            lpi_trans_q <= '0;
        end else if (lpi_run && lpi_rise) begin
            lpi_trans_q <= lpi_trans_q + 1'b1;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            lpi_time_q <= '0;
        end else if (!energy_efficient_enable_i) begin
            lpi_time_q <= '0;
        end else if (lpi_run && lpi_q && us_tick_q) begin
            lpi_time_q <= lpi_time_q + 1'b1;
        end
    end

    assign rx_lpi_transitions_o = lpi_trans_q;
    assign rx_lpi_time_o = lpi_time_q;

    lpi_zero_a: assert property (!energy_efficient_enable_i |=>
        (lpi_trans_q == '0) && (lpi_time_q == '0))
        else $error("LPI counters not held at zero while disabled");
    lpi_edge_a: assert property (energy_efficient_enable_i && lpi_run && lpi_rise
        |=> lpi_trans_q == $past(lpi_trans_q) + 1'b1)
        else $error("LPI rising edge not counted");
    lpi_time_a: assert property (energy_efficient_enable_i && lpi_run && lpi_q
        && us_tick_q |=> lpi_time_q == $past(lpi_time_q) + 1'b1)
        else $error("LPI microsecond not accumulated");
    lpi_hold_a: assert property (energy_efficient_enable_i && !lpi_run
        |=> $stable(lpi_trans_q) && $stable(lpi_time_q))
        else $error("LPI counters moved outside counting power states");
    us_tick_a: assert property (us_tick_q |=> !us_tick_q [*8])
        else $error("Microsecond tick spacing wrong");

    // ****************************************************************
    // Force bad FCS
    // ****************************************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tx_corrupt_fcs_o <= 1'b0;
        end else begin
            tx_corrupt_fcs_o <= force_bad_fcs_i;
        end
    end

    // ****************************************************************
    // Deferral timer
    // ****************************************************************
    assign defer_limit = {1'b0, max_frame_size_i, 1'b0} + DEFER_MARGIN_BYTES;
    assign defer_over = tx_defer_i && (defer_q > defer_limit);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            defer_q <= '0;
        end else if (!tx_defer_i) begin
            defer_q <= '0;
        end else if (tx_byte_tick_i && (defer_q != '1)) begin
            defer_q <= defer_q + 1'b1;
        end
    end

    // Sticky per frame; a new overrun beats the end-of-frame clear
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            defer_excess_q <= 1'b0;
        end else if (defer_over) begin
            defer_excess_q <= 1'b1;
        end else if (tx_done_i || col_excess) begin
            defer_excess_q <= 1'b0;
        end
    end

    assign frame_defer_excess = defer_excess_q | defer_over;

    defer_restart_a: assert property (!tx_defer_i |=> defer_q == '0)
        else $error("Deferral timer did not restart");

    // ****************************************************************
    // Collision tracking
    // ****************************************************************
    assign col_excess = tx_collision_i && (col_q == MAX_COLLISIONS - 1'b1);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            col_q <= '0;
        end else if (col_excess || tx_done_i) begin
            col_q <= '0;
        end else if (tx_collision_i) begin
            col_q <= col_q + 1'b1;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tx_abort_o <= 1'b0;
        end else begin
            tx_abort_o <= col_excess;
        end
    end

    xcol_abort_a: assert property (tx_collision_i && (col_q == 5'h0F)
        |=> tx_abort_o && (fc_cnt[FC_XCOL] == $past(fc_cnt[FC_XCOL]) + 1'b1))
        else $error("Sixteenth collision did not abort and count");

    // ****************************************************************
    // Frame qualification
    // ****************************************************************
    assign rx_good = rx_done_i & ~rx_err_i & ~rx_filter_reject_i & ~rx_fifo_overflow_i;
    assign tx_err = tx_fcs_err_i | tx_corrupt_fcs_o | tx_carrier_err_i | tx_late_col_i
        | frame_defer_excess;
    assign tx_ok = tx_done_i & ~tx_err;
    assign tx_full = tx_ok & ~tx_partial_i;

    // Each lane fires once, on the frame's closing strobe; the excess-collision lane fires on the sixteenth collision
    always_comb begin
        fc_inc = '0;
        fc_inc[FC_RX512] = rx_good && len_in(rx_len_i, BIN_512, BIN_1023);
        fc_inc[FC_RX1024] = rx_good && len_in(rx_len_i, BIN_1024, BIN_1518);
        fc_inc[FC_RXBIG] = rx_good && len_in(rx_len_i, BIN_1519, LEN_MAX);
        fc_inc[FC_FCS] = tx_done_i && (tx_fcs_err_i || tx_corrupt_fcs_o);
        fc_inc[FC_DEFER] = tx_done_i && frame_defer_excess;
        fc_inc[FC_CARRIER] = tx_done_i && tx_carrier_err_i;
        fc_inc[FC_SCOL] = tx_ok && (col_q == 5'h01);
        fc_inc[FC_MCOL] = tx_ok && (col_q > 5'h01);
        fc_inc[FC_XCOL] = col_excess;
        fc_inc[FC_LCOL] = tx_done_i && tx_late_col_i;
        fc_inc[FC_UNI] = tx_ok && tx_unicast_i && !tx_pause_i;
        fc_inc[FC_BC] = tx_ok && tx_broadcast_i && !tx_pause_i;
        fc_inc[FC_MC] = tx_ok && tx_multicast_i && !tx_pause_i;
        fc_inc[FC_PAUSE] = tx_ok && tx_pause_i;
        fc_inc[FC_T64] = tx_full && !tx_pause_i && (tx_len_i == BIN_64);
        fc_inc[FC_T65] = tx_full && len_in(tx_len_i, BIN_65, BIN_127);
        fc_inc[FC_T128] = tx_full && len_in(tx_len_i, BIN_128, BIN_255);
        fc_inc[FC_T256] = tx_full && len_in(tx_len_i, BIN_256, BIN_511);
    end

    always_comb begin
        bc_inc = '0;
        bc_inc[BC_BAD] = tx_done_i && tx_err;
        bc_inc[BC_UNI] = tx_full && tx_unicast_i && !tx_pause_i;
        bc_inc[BC_BC] = tx_full && tx_broadcast_i && !tx_pause_i;
        bc_inc[BC_MC] = tx_full && tx_multicast_i && !tx_pause_i;
    end

    // ****************************************************************
    // Counter banks
    // ****************************************************************
    msc_counter_bank #(
        .N(FC_N),
        .W(CNT20_W),
        .AW(1)
    ) u_frames (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .inc_i(fc_inc),
        .amount_i(1'b1),
        .count_o(fc_cnt)
    );

    msc_counter_bank #(
        .N(BC_N),
        .W(CNT32_W),
        .AW(LEN_W)
    ) u_bytes (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .inc_i(bc_inc),
        .amount_i(tx_len_i),
        .count_o(bc_cnt)
    );

    assign rx_frames_512_o = fc_cnt[FC_RX512];
    assign rx_frames_1024_o = fc_cnt[FC_RX1024];
    assign rx_frames_big_o = fc_cnt[FC_RXBIG];
    assign tx_fcs_errors_o = fc_cnt[FC_FCS];
    assign tx_excess_defer_o = fc_cnt[FC_DEFER];
    assign tx_carrier_errors_o = fc_cnt[FC_CARRIER];
    assign tx_single_col_o = fc_cnt[FC_SCOL];
    assign tx_multi_col_o = fc_cnt[FC_MCOL];
    assign tx_excess_col_o = fc_cnt[FC_XCOL];
    assign tx_late_col_o = fc_cnt[FC_LCOL];
    assign tx_unicast_frames_o = fc_cnt[FC_UNI];
    assign tx_broadcast_frames_o = fc_cnt[FC_BC];
    assign tx_multicast_frames_o = fc_cnt[FC_MC];
    assign tx_pause_frames_o = fc_cnt[FC_PAUSE];
    assign tx_frames_64_o = fc_cnt[FC_T64];
    assign tx_frames_65_o = fc_cnt[FC_T65];
    assign tx_frames_128_o = fc_cnt[FC_T128];
    assign tx_frames_256_o = fc_cnt[FC_T256];
    assign tx_bad_bytes_o = bc_cnt[BC_BAD];
    assign tx_unicast_bytes_o = bc_cnt[BC_UNI];
    assign tx_broadcast_bytes_o = bc_cnt[BC_BC];
    assign tx_multicast_bytes_o = bc_cnt[BC_MC];

    // ****************************************************************
    // Counter checks
    // ****************************************************************
    rx_bin512_a: assert property (rx_good && (rx_len_i >= 14'h0200)
        && (rx_len_i <= 14'h03FF) |=> rx_frames_512_o == $past(rx_frames_512_o) + 1'b1)
        else $error("512-1023 receive bin missed a frame");
    rx_bin1024_a: assert property (rx_good && (rx_len_i == 14'h05EE)
        |=> rx_frames_1024_o == $past(rx_frames_1024_o) + 1'b1)
        else $error("1518-byte frame not in 1024-1518 bin");
    rx_bigbin_a: assert property (rx_good && (rx_len_i == 14'h05EE)
        |=> $stable(rx_frames_big_o))
        else $error("1518-byte frame counted as oversize");
    rx_reject_a: assert property (rx_done_i && (rx_filter_reject_i || rx_fifo_overflow_i)
        |=> $stable(rx_frames_512_o) && $stable(rx_frames_1024_o) && $stable(rx_frames_big_o))
        else $error("Rejected receive frame was binned");
    fcs_force_a: assert property (tx_done_i && tx_corrupt_fcs_o
        |=> tx_fcs_errors_o == $past(tx_fcs_errors_o) + 1'b1)
        else $error("Forced bad FCS frame not counted");
    single_col_a: assert property (tx_ok && (col_q == 5'h01)
        |=> (tx_single_col_o == $past(tx_single_col_o) + 1'b1) && $stable(tx_multi_col_o))
        else $error("Single collision frame miscounted");
    bad_bytes_a: assert property (tx_done_i && tx_late_col_i
        |=> tx_bad_bytes_o == $past(tx_bad_bytes_o) + CNT32_W'($past(tx_len_i)))
        else $error("Errored transmit bytes not totalled");
    pause_bytes_a: assert property (tx_done_i && tx_pause_i
        |=> $stable(tx_unicast_bytes_o) && $stable(tx_multicast_bytes_o))
        else $error("Pause frame bytes entered cast byte totals");
    bin64_a: assert property (tx_done_i && (tx_pause_i || tx_partial_i)
        |=> $stable(tx_frames_64_o))
        else $error("Pause or partial frame entered 64-byte bin");

    rx_bin_c: cover property (rx_good ##1 rx_frames_1024_o != '0);
    lpi_time_c: cover property (lpi_rise ##[1:200] lpi_time_q != '0);
    xcol_c: cover property (col_excess ##1 tx_abort_o);

endmodule

// File: bench/msc_phy_model.sv
// Far-side PHY model driving the low-power-idle indication
`timescale 1ns/1ps
module msc_phy_model (
    // Clock
    input wire logic clock_i,
    // Low-power-idle indication
    output logic lpi_o
);
    initial lpi_o = 1'b0;
    // Idle indication high for n cycles, then low for q cycles
    task automatic lpi_burst(input int n, input int q);
        @(negedge clock_i);
        lpi_o = 1'b1;
        repeat (n) @(negedge clock_i);
        lpi_o = 1'b0;
        repeat (q) @(negedge clock_i);
    endtask
endmodule

// File: bench/msc_stats_tb.sv
// Self-checking bench for the statistics counters
`timescale 1ns/1ps
module msc_stats_tb
    import msc_pkg::*;
;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic rx_done_i, rx_err_i, rx_filter_reject_i, rx_fifo_overflow_i, tx_done_i, tx_fcs_err_i;
    logic tx_carrier_err_i, tx_late_col_i, tx_unicast_i, tx_broadcast_i, tx_multicast_i;
    logic tx_pause_i, tx_partial_i, force_bad_fcs_i, tx_collision_i, phy_lpi_i, tx_defer_i;
    logic energy_efficient_enable_i, pwr_normal_i, suspend_level_zero_i, suspend_level_three_i;
    logic tx_byte_tick_i, tx_corrupt_fcs_o, tx_abort_o;
    logic [LEN_W-1:0] rx_len_i = 14'h0000, tx_len_i = 14'h0000, max_frame_size_i = 14'h05EE;
    logic [3:0] rxv = 4'h0;
    logic [9:0] txv = 10'h000;
    logic [6:0] ctl = 7'h00;
    logic [CNT20_W-1:0] rx_frames_512_o, rx_frames_1024_o, rx_frames_big_o, tx_fcs_errors_o;
    logic [CNT20_W-1:0] tx_excess_defer_o, tx_carrier_errors_o, tx_single_col_o, tx_multi_col_o;
    logic [CNT20_W-1:0] tx_excess_col_o, tx_late_col_o, tx_unicast_frames_o, tx_frames_64_o;
    logic [CNT20_W-1:0] tx_broadcast_frames_o, tx_multicast_frames_o, tx_pause_frames_o;
    logic [CNT20_W-1:0] tx_frames_65_o, tx_frames_128_o, tx_frames_256_o;
    logic [CNT32_W-1:0] rx_lpi_transitions_o, rx_lpi_time_o, tx_bad_bytes_o, tx_unicast_bytes_o;
    logic [CNT32_W-1:0] tx_broadcast_bytes_o, tx_multicast_bytes_o;
    int n_fail = 0, tests_run = 0, cyc = 0;
    int m[16], mf[3], mb[3], mt[3];
    int lens[8] = '{64, 511, 512, 1023, 1024, 1518, 1519, 16383};
    assign {rx_done_i, rx_err_i, rx_filter_reject_i, rx_fifo_overflow_i} = rxv;
    assign {tx_done_i, tx_fcs_err_i, tx_carrier_err_i, tx_late_col_i, tx_unicast_i, tx_broadcast_i,
        tx_multicast_i, tx_pause_i, tx_partial_i, tx_collision_i} = txv;
    assign {force_bad_fcs_i, energy_efficient_enable_i, pwr_normal_i, suspend_level_zero_i,
        suspend_level_three_i, tx_byte_tick_i, tx_defer_i} = ctl;
    msc_stats DUT (.*);
    msc_phy_model PHY (.clock_i(clock_i), .lpi_o(phy_lpi_i));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic close_out;
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic pulse;
        @(negedge clock_i);
        txv = 10'h001;
        @(negedge clock_i);
        txv = 10'h000;
    endtask
    initial begin
        forever #10 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            close_out;
        end
    end
    initial begin
        int len, f, nc, ci;
        logic err;
        logic [2:0] cst;
        void'($urandom(32'h30A711FA));
        repeat (6) @(negedge clock_i);
        rst_i = 1'b0;
        for (int i = 0; i < 60; i++) begin
            len = (i < 8) ? lens[i] : $urandom_range(3000, 300);
            f = ($urandom % 2) ? 0 : $urandom % 8;
            rx_len_i = LEN_W'(len);
            rxv = {1'b1, f[2:0]};
            m[len < 512 ? 15 : len < 1024 ? 0 : len < 1519 ? 1 : 2] += (f == 0);
            @(negedge clock_i);
            rxv = 4'h0;
            chk(rx_frames_512_o, m[0]);
            chk(rx_frames_1024_o, m[1]);
            chk(rx_frames_big_o, m[2]);
            @(negedge clock_i);
        end
        for (int i = 0; i < 80; i++) begin
            f = $urandom;
            len = (i % 4 == 0) ? 64 : $urandom_range(600, 60);
            nc = f[20:19] % 3;
            cst = (f[13:12] == 0) ? 3'b100 : f[13] ? 3'b001 : 3'b010;
            ci = cst[2] ? 0 : cst[1] ? 1 : 2;
            ctl[6] = (f[2:0] == 0);
            repeat (nc) pulse();
            @(negedge clock_i);
            tx_len_i = LEN_W'(len);
            txv = {1'b1, f[5:3] == 0, f[8:6] == 0, f[11:9] == 0, cst, f[15:14] == 0,
                f[18:16] == 0, 1'b0};
            err = txv[8] | ctl[6] | txv[7] | txv[6];
            m[3] += txv[8] | ctl[6];
            m[4] += err ? len : 0;
            m[5] += txv[7];
            m[6] += txv[6];
            if (!err) begin
                mf[ci] += !txv[2];
                mb[ci] += (!txv[2] & !txv[1]) ? len : 0;
                mt[len < 128 ? 0 : len < 256 ? 1 : 2] += !txv[1] & (len > 64) & (len < 512);
                m[9] += txv[2];
                m[10] += (len == 64) & !txv[2] & !txv[1];
                m[11] += (nc == 1);
                m[12] += (nc == 2);
            end
            @(negedge clock_i);
            txv = 10'h000;
            chk(tx_fcs_errors_o, m[3]);
            chk(tx_bad_bytes_o, m[4]);
            chk(tx_carrier_errors_o, m[5]);
            chk(tx_late_col_o, m[6]);
            chk(tx_unicast_frames_o, mf[0]);
            chk(tx_broadcast_frames_o, mf[1]);
            chk(tx_multicast_frames_o, mf[2]);
            chk(tx_unicast_bytes_o, mb[0]);
            chk(tx_broadcast_bytes_o, mb[1]);
            chk(tx_multicast_bytes_o, mb[2]);
            chk(tx_frames_65_o, mt[0]);
            chk(tx_frames_128_o, mt[1]);
            chk(tx_frames_256_o, mt[2]);
            chk(tx_corrupt_fcs_o, ctl[6]);
            chk(tx_pause_frames_o, m[9]);
            chk(tx_frames_64_o, m[10]);
            chk(tx_single_col_o, m[11]);
            chk(tx_multi_col_o, m[12]);
        end
        repeat (16) pulse();
        chk(tx_abort_o, 1);
        chk(tx_excess_col_o, 1);
        @(negedge clock_i);
        chk(tx_abort_o, 0);
        ctl[6] = 1'b0;
        max_frame_size_i = 14'h0010;
        tx_len_i = 14'h0258;
        for (int k = 0; k < 3; k++) begin
            ctl[1:0] = 2'b11;
            repeat (k == 2 ? 60 : 40) @(negedge clock_i);
            ctl[1:0] = 2'b00;
            txv = {k > 0, 9'h000};
            m[4] += (k == 2) ? 600 : 0;
            @(negedge clock_i);
            txv = 10'h000;
            chk(tx_excess_defer_o, k / 2);
            chk(tx_bad_bytes_o, m[4]);
        end
        ctl[5] = 1'b1;
        for (int k = 0; k < 4; k++) begin
            ctl[4:2] = 3'b100 >> k;
            PHY.lpi_burst(120, 10);
            chk(rx_lpi_transitions_o, (k > 2) ? 3 : k + 1);
        end
        chk(rx_lpi_time_o >= 6 && rx_lpi_time_o <= 9, 1);
        ctl[5] = 1'b0;
        repeat (2) @(negedge clock_i);
        chk(rx_lpi_transitions_o, 0);
        chk(rx_lpi_time_o, 0);
        close_out;
    end
endmodule
